// ### glob_regs.sv
// global control and memory configuration register bank behind APB
//
// Design decision made here: register access over APB.
`timescale 1ns/1ns
module glob_regs #(
  parameter logic [3:0] STEPPING = 4'h5  // arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_irq_pin,
  output logic             ext_irq_req,
  output logic             core_clock_select,
  output logic             pullup_disable,
  output logic             low_power_disable,
  output logic             codec_port_enable,
  output logic             boot_shadow_switch
);

  // ****************************************
  // bus decode
  // ****************************************
  logic [7:0]  gctl_q, gctl_d;
  logic        shadow_q, shadow_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic        irq_s1_q, irq_s2_q, irq_q, irq_d;
  logic        hit_gc, hit_mc, access, commit, wr_ok;
  logic [7:0]  mc_val;

  // readback of the read-only fields is wired, not stored
  assign mc_val = {glob_regs_pkg::MC_TYPE_RAM, glob_regs_pkg::MC_SIZE_8K,
                   STEPPING, shadow_q};
  assign hit_gc = paddr[glob_regs_pkg::ADDR_W-1:0] == glob_regs_pkg::GLOBAL_CONTROL_ADDR
                  && paddr[31:glob_regs_pkg::ADDR_W] == '0;
  assign hit_mc = paddr[glob_regs_pkg::ADDR_W-1:0] == glob_regs_pkg::MEMORY_CONFIG_ADDR
                  && paddr[31:glob_regs_pkg::ADDR_W] == '0;
  // one wait state: answer comes the cycle after penable rises
  assign access = psel && penable && !pready_q;
  // writes land at the edge where the master sees pready high, never earlier,
  // so a control bit never moves while the transfer still looks unanswered
  assign commit = psel && penable && pready_q;
  assign wr_ok  = commit && pwrite && pstrb[0];

  // ****************************************
  // register next state and bus answer
  // ****************************************
  // read data is loaded at the access edge and stands while pready is high
  always_comb begin
    gctl_d    = gctl_q;
    shadow_d  = shadow_q;
    prdata_d  = 32'h0000_0000;
    pready_d  = access;
    pslverr_d = access && !(hit_gc || hit_mc);
    if (wr_ok && hit_gc) begin
      // reserved bits stay zero through the write mask
      gctl_d = pwdata[7:0] & glob_regs_pkg::GC_WRITE_MASK;
    end
    // shadow switch is one way; a zero write cannot return to boot mode
    if (wr_ok && hit_mc && pwdata[glob_regs_pkg::MC_SHADOW_BIT]) begin
      shadow_d = 1'h1;
    end
    // reads return zero unless the address hits; the error flag marks a miss
    if (access && !pwrite && hit_gc) begin
      prdata_d = {24'h00_0000, gctl_q};
    end else if (access && !pwrite && hit_mc) begin
      prdata_d = {24'h00_0000, mc_val};
    end
    // pin is ignored while the enable is clear
    irq_d = irq_s2_q && gctl_q[glob_regs_pkg::GC_EXT_IRQ_BIT];
  end

  // ****************************************
  // register stage
  // ****************************************
  // only constants in the reset branch; the pin flops clear too, so a pin
  // held high through reset shows up two cycles after release, not at once
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gctl_q    <= glob_regs_pkg::GC_RESET;
      shadow_q  <= glob_regs_pkg::MC_SHADOW_RESET;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'h0;
      pslverr_q <= 1'h0;
      irq_s1_q  <= 1'h0;
      irq_s2_q  <= 1'h0;
      irq_q     <= 1'h0;
    end else begin
      gctl_q    <= gctl_d;
      shadow_q  <= shadow_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      irq_s1_q  <= ext_irq_pin;
      irq_s2_q  <= irq_s1_q;
      irq_q     <= irq_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // every output is a flop or a bit of one; nothing combinational reaches a pin
  // the control bits steer other blocks; only the interrupt enable bit also gates this bank's interrupt request
  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign ext_irq_req        = irq_q;
  assign core_clock_select  = gctl_q[glob_regs_pkg::GC_CORE_CLK_BIT];
  assign pullup_disable     = gctl_q[glob_regs_pkg::GC_PULLUP_BIT];
  assign low_power_disable  = gctl_q[glob_regs_pkg::GC_LOW_PWR_BIT];
  assign codec_port_enable  = gctl_q[glob_regs_pkg::GC_CODEC_BIT];
  assign boot_shadow_switch = shadow_q;

  // ****************************************
  // assertions
  // ****************************************
  // all checks run on the one clock and rest while reset is low
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // global control bits follow each accepted write
  a_gc_write_lands: assert property (
    psel && penable && pready && pwrite && pstrb[0] && hit_gc
    |=> core_clock_select == $past(pwdata[7]) && pullup_disable == $past(pwdata[5]))
    else $error("global control write not applied");
  a_irq_gated: assert property (
    !gctl_q[glob_regs_pkg::GC_EXT_IRQ_BIT] |=> !ext_irq_req)
    else $error("interrupt passed while disabled");
  a_irq_follows: assert property (
    gctl_q[glob_regs_pkg::GC_EXT_IRQ_BIT] && $stable(gctl_q) && irq_s2_q |=> ext_irq_req)
    else $error("enabled interrupt not passed");
  a_lowpwr_hold: assert property (
    !(wr_ok && hit_gc) && !low_power_disable |=> !low_power_disable)
    else $error("low power disable rose without write");
  a_lowpwr_write: assert property (
    wr_ok && hit_gc |=> low_power_disable == $past(pwdata[2]))
    else $error("low power disable not written");
  a_irq_en_write: assert property (
    wr_ok && hit_gc |=> gctl_q[glob_regs_pkg::GC_EXT_IRQ_BIT] == $past(pwdata[6]))
    else $error("interrupt enable not written");

  // control levels only move on an accepted write
  a_clk_sel_hold: assert property (
    !(wr_ok && hit_gc) |=> $stable(core_clock_select))
    else $error("clock select changed without write");
  a_pullup_hold: assert property (
    !(wr_ok && hit_gc) |=> $stable(pullup_disable))
    else $error("pullup disable changed without write");
  a_codec_hold: assert property (
    !(wr_ok && hit_gc) |=> $stable(codec_port_enable))
    else $error("codec enable changed without write");
  a_codec_en: assert property (
    psel && penable && pready && pwrite && pstrb[0] && hit_gc
    |=> codec_port_enable == $past(pwdata[0]))
    else $error("codec enable not written");
  a_mc_fixed: assert property (
    pready && !pwrite && hit_mc && !pslverr |-> prdata[7:5] == 3'h5)
    else $error("fixed memory fields wrong");
  a_step_read: assert property (
    pready && !pwrite && hit_mc |-> prdata[4:1] == STEPPING)
    else $error("stepping code wrong");
  a_shadow_sticky: assert property (
    boot_shadow_switch |=> boot_shadow_switch)
    else $error("shadow switch fell");
  a_shadow_set: assert property (
    wr_ok && hit_mc && pwdata[0] |=> boot_shadow_switch)
    else $error("shadow switch not set");
  a_reserved_zero: assert property (
    (gctl_q & ~glob_regs_pkg::GC_WRITE_MASK) == 8'h00)
    else $error("reserved bits set");
  a_reserved_read: assert property (
    pready && !pwrite && hit_gc |-> prdata[4:3] == 2'h0 && prdata[1] == 1'h0)
    else $error("reserved bits read nonzero");

  // bus answer shape: one wait state, one-cycle answer, clean error reads
  a_one_wait: assert property (
    psel && !penable ##1 psel && penable |=> pready)
    else $error("answer not after one wait");
  a_ready_pulse: assert property (
    pready |=> !pready)
    else $error("ready held over two cycles");
  a_error_quiet: assert property (
    pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error answer carried data");
  a_upper_zero: assert property (
    pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  a_no_strobe: assert property (
    psel && penable && pready && pwrite && !pstrb[0]
    |=> $stable(gctl_q) && $stable(shadow_q))
    else $error("write without byte strobe took effect");

  // main scenarios
  c_gc_write: cover property (pready && pwrite && hit_gc);
  c_mc_read:  cover property (pready && !pwrite && hit_mc);
  c_shadow:   cover property ($rose(boot_shadow_switch));
  c_bad_addr: cover property (pready && pslverr);
  c_irq:      cover property ($rose(ext_irq_req));

endmodule

// ### glob_regs_pkg.sv
// constants for the global control and memory configuration registers
package glob_regs_pkg;
  // ****************************************
  // register indices and byte addresses
  // ****************************************
  // printed offsets are not all multiples of four, so they serve as indices
  localparam logic [15:0] MEMORY_CONFIG_IDX  = 16'hFFB0;
  localparam logic [15:0] GLOBAL_CONTROL_IDX = 16'hFFB1;
  localparam logic [17:0] MEMORY_CONFIG_ADDR  = {MEMORY_CONFIG_IDX, 2'h0};
  localparam logic [17:0] GLOBAL_CONTROL_ADDR = {GLOBAL_CONTROL_IDX, 2'h0};
  localparam int ADDR_W = 18;

  // ****************************************
  // global control fields
  // ****************************************
  localparam int GC_CORE_CLK_BIT  = 7;
  localparam int GC_EXT_IRQ_BIT   = 6;
  localparam int GC_PULLUP_BIT    = 5;
  localparam int GC_LOW_PWR_BIT   = 2;
  localparam int GC_CODEC_BIT     = 0;
  localparam logic [7:0] GC_WRITE_MASK = 8'hE5;
  localparam logic [7:0] GC_RESET      = 8'h00;

  // ****************************************
  // memory configuration fields
  // ****************************************
  localparam int MC_TYPE_BIT     = 7;
  localparam int MC_SIZE_LSB     = 5;
  localparam int MC_STEP_LSB     = 1;
  localparam int MC_SHADOW_BIT   = 0;
  localparam logic       MC_TYPE_RAM  = 1'h1;
  localparam logic [1:0] MC_SIZE_8K   = 2'h1;
  localparam logic       MC_SHADOW_RESET = 1'h0;
endpackage

// ### tb_top.sv
// self-checking bench for the global control and memory configuration registers
`timescale 1ns/1ns
module tb_top;
  // ********************************
  // stimulus, clock and reset
  // ********************************
  localparam logic [31:0] GA    = 32'(glob_regs_pkg::GLOBAL_CONTROL_ADDR);
  localparam logic [31:0] MA    = 32'(glob_regs_pkg::MEMORY_CONFIG_ADDR);
  localparam logic [3:0]  STEP  = 4'hA;  // arbitrary stepping value
  localparam int          LIMIT = 20;    // cycles allowed for one answer
  logic        clk         = 1'h0;
  logic        reset_n     = 1'h0;
  logic        psel        = 1'h0;
  logic        penable     = 1'h0;
  logic        pwrite      = 1'h0;
  logic        ext_irq_pin = 1'h0;
  logic [31:0] paddr       = 32'h0000_0000;
  logic [31:0] pwdata      = 32'h0000_0000;
  logic [3:0]  pstrb       = 4'h0;
  logic [31:0] prdata;
  logic [31:0] r;
  logic        pready;
  logic        pslverr;
  logic        ext_irq_req;
  logic        e;
  logic        core_clock_select;
  logic        pullup_disable;
  logic        low_power_disable;
  logic        codec_port_enable;
  logic        boot_shadow_switch;
  int          num_errors  = 0;
  int          n_compared  = 0;
  wire  [5:0]  outs = {core_clock_select, ext_irq_req, pullup_disable, low_power_disable,
                       codec_port_enable, boot_shadow_switch};
  glob_regs #(
    .STEPPING(STEP)
  ) u_glob_regs (
    .clk                (clk),
    .reset_n            (reset_n),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .pstrb              (pstrb),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .ext_irq_pin        (ext_irq_pin),
    .ext_irq_req        (ext_irq_req),
    .core_clock_select  (core_clock_select),
    .pullup_disable     (pullup_disable),
    .low_power_disable  (low_power_disable),
    .codec_port_enable  (codec_port_enable),
    .boot_shadow_switch (boot_shadow_switch)
  );
  initial begin
    forever #4 clk = ~clk;
  end
  // ********************************
  // shared bus and compare tasks
  // ********************************
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // one apb transfer: the request stands until pready is seen high at an edge,
  // then one idle edge passes so back-to-back calls never touch psel twice
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < LIMIT);
    r = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    if (n >= LIMIT) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, pready, 1'h1);
      test_done();
    end
    @(posedge clk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'h1, a, d, 4'hF);
  endtask
  task automatic rd(input logic [31:0] a);
    apb(1'h0, a, 32'h0000_0000, 4'h0);
  endtask
  // ********************************
  // scenarios
  // ********************************
  task automatic t_reset();
    rd(GA);
    chk(r, 32'h0000_0000);
    rd(MA);
    chk(r, {24'h00_0000, 3'h5, STEP, 1'h0});
    chk(32'(outs), 32'h0000_0000);
    $display("reset values done");
  endtask
  task automatic t_global();
    wr(GA, 32'h0000_00FF);
    chk(32'(outs), 32'h0000_002E);
    rd(GA);
    chk(r, 32'h0000_00E5);
    apb(1'h1, GA, 32'h0000_0000, 4'h0);
    rd(GA);
    chk(r, 32'h0000_00E5);
    wr(GA, 32'h0000_0004);
    chk(32'(outs), 32'h0000_0004);
    $display("global control done");
  endtask
  // irq request follows the synchronised pin only while enabled
  task automatic t_irq();
    ext_irq_pin <= 1'h1;
    wr(GA, 32'h0000_0044);
    repeat (4) @(posedge clk);
    chk(32'(ext_irq_req), 32'h0000_0001);
    ext_irq_pin <= 1'h0;
    repeat (4) @(posedge clk);
    chk(32'(ext_irq_req), 32'h0000_0000);
    ext_irq_pin <= 1'h1;
    wr(GA, 32'h0000_0004);
    repeat (4) @(posedge clk);
    chk(32'(ext_irq_req), 32'h0000_0000);
    ext_irq_pin <= 1'h0;
    $display("external interrupt done");
  endtask
  task automatic t_memory_config();
    wr(MA, 32'h0000_0000);
    chk(32'(boot_shadow_switch), 32'h0000_0000);
    wr(MA, 32'h0000_00FF);
    chk(32'(boot_shadow_switch), 32'h0000_0001);
    rd(MA);
    chk(r, {24'h00_0000, 3'h5, STEP, 1'h1});
    wr(MA, 32'h0000_0000);
    chk(32'(boot_shadow_switch), 32'h0000_0001);
    $display("memory config done");
  endtask
  // misses answer with an error, carry no data and change nothing
  task automatic t_unmapped();
    rd(32'h0000_0100);
    chk(r, 32'h0000_0000);
    chk(32'(e), 32'h0000_0001);
    wr(GA | 32'h0004_0000, 32'h0000_00FF);
    chk(32'(e), 32'h0000_0001);
    rd(GA);
    chk(r, 32'h0000_0004);
    chk(32'(e), 32'h0000_0000);
    $display("unmapped access done");
  endtask
  // a second reset clears every control bit and the shadow switch
  task automatic t_rereset();
    reset_n <= 1'h0;
    repeat (2) @(posedge clk);
    chk(32'(outs), 32'h0000_0000);
    reset_n <= 1'h1;
    @(posedge clk);
    rd(MA);
    chk(r, {24'h00_0000, 3'h5, STEP, 1'h0});
    $display("second reset done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'h1;
    @(posedge clk);
    t_reset();
    t_global();
    t_irq();
    t_memory_config();
    t_unmapped();
    t_rereset();
    test_done();
  end
endmodule
